/* File: rtl/nvac_access_ctrl.sv */
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "nvac_defines.svh"
module nvac_access_ctrl
	import nvac_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `NVAC_PROG_CYC
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// axi4-lite write address and data
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	// axi4-lite write response
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// axi4-lite read
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// status
	output logic o_irq,
	output logic o_cpu_stall
);
	// data EEPROM array and flash holding registers
	logic [7:0] eeprom_mem [0:255];
	logic [7:0] hold_mem [0:`NVAC_HOLD_N-1];
	logic [7:0] pfm_mem [0:1023];
	logic [7:0] cfg_mem [0:255];
	logic [7:0] nv_data_reg_r;
	logic [7:0] nv_addr_low_r;
	logic [7:0] nv_addr_high_r;
	nvac_ctrl_t ctrl_r;
	logic program_fault_flag_r;
	logic nv_done_flag_r;
	logic done_mask_r;
	logic [7:0] table_latch_reg_r;
	logic [5:0] hold_idx_r;
	logic [1:0] unlock_r;
	nvac_state_t state_r;
	logic timer_start;
	logic timer_expired;
	// bus side
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go;
	logic rd_go;
	logic [7:0] wbyte;
	logic [31:0] rd_val;
	logic rd_hit;
	logic [9:0] pfm_addr;

	// a byte lane 0 write is all this byte-wide block honours
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	assign wbyte = w_data_r[7:0];
	assign wr_go = aw_held_r && w_held_r && !o_bvalid && w_strb_r[0];
	assign rd_go = i_arvalid && o_arready;
	assign pfm_addr = {nv_addr_high_r[1:0], nv_addr_low_r};
	assign timer_start = (state_r == NVAC_IDLE) && ctrl_r.wr;

	// write address and data may arrive in either order
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= 2'h0;
		end else begin
			o_awready <= !aw_held_r && !i_awvalid ? 1'b1 : !aw_held_r && !o_awready;
			o_wready <= !w_held_r && !i_wvalid ? 1'b1 : !w_held_r && !o_wready;
			if (i_awvalid && o_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= i_wdata;
				w_strb_r <= i_wstrb;
				o_wready <= 1'b0;
			end
			if (aw_held_r && w_held_r && !o_bvalid) begin
				o_bvalid <= 1'b1;
				o_bresp <= (aw_addr_r > `NVAC_OFS_MASK || aw_addr_r[1:0] != 2'h0)
					? 2'h2 : 2'h0; // unmapped gives slverr
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
			end
		end
	end

	// read decode, if/else-if chain over offsets
	always_comb begin
		rd_val = 32'h0;
		rd_hit = 1'b1;
		if (hit(i_araddr, `NVAC_OFS_DATA)) begin
			rd_val[7:0] = nv_data_reg_r;
		end else if (hit(i_araddr, `NVAC_OFS_ADRL)) begin
			rd_val[7:0] = nv_addr_low_r;
		end else if (hit(i_araddr, `NVAC_OFS_ADRH)) begin
			rd_val[7:0] = nv_addr_high_r;
		end else if (hit(i_araddr, `NVAC_OFS_CTRL)) begin
			rd_val[`NVAC_CTRL_TGT_LO+1:`NVAC_CTRL_TGT_LO] = ctrl_r.target;
			rd_val[`NVAC_CTRL_FREE] = ctrl_r.free;
			rd_val[`NVAC_CTRL_ERR] = program_fault_flag_r;
			rd_val[`NVAC_CTRL_MODIFY_PERMIT] = ctrl_r.modify_permit;
			rd_val[`NVAC_CTRL_WR] = ctrl_r.wr;
			rd_val[`NVAC_CTRL_RD] = ctrl_r.rd;
		end else if (hit(i_araddr, `NVAC_OFS_UNLK)) begin
			rd_val = 32'h0; // unlock register reads as zero
		end else if (hit(i_araddr, `NVAC_OFS_LATCH)) begin
			rd_val[7:0] = table_latch_reg_r;
		end else if (hit(i_araddr, `NVAC_OFS_TSTORE)) begin
			rd_val[5:0] = hold_idx_r;
		end else if (hit(i_araddr, `NVAC_OFS_PERIPHERAL_FLAG_REG7)) begin
			rd_val[`NVAC_PERIPHERAL_FLAG_REG7_DONE] = nv_done_flag_r;
		end else if (hit(i_araddr, `NVAC_OFS_MASK)) begin
			rd_val[`NVAC_PERIPHERAL_FLAG_REG7_DONE] = done_mask_r;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// read channel: one beat, one cycle after the address is taken
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			o_rresp <= 2'h0;
		end else begin
			o_arready <= !o_rvalid && !rd_go;
			if (rd_go) begin
				o_rvalid <= 1'b1;
				o_rdata <= rd_val;
				o_rresp <= rd_hit ? 2'h0 : 2'h2;
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// address pair and table latch
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			nv_addr_low_r <= 8'h00;
			nv_addr_high_r <= 8'h00;
			table_latch_reg_r <= 8'h00;
		end else if (wr_go) begin
			if (hit(aw_addr_r, `NVAC_OFS_ADRL)) begin
				nv_addr_low_r <= wbyte; // RQ1
			end else if (hit(aw_addr_r, `NVAC_OFS_ADRH)) begin
				nv_addr_high_r <= wbyte; // RQ1
			end else if (hit(aw_addr_r, `NVAC_OFS_LATCH)) begin
				table_latch_reg_r <= wbyte;
			end
		end
	end

	// unlock tracker: any other bus write breaks the sequence
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			unlock_r <= 2'h0;
		end else if (wr_go) begin
			if (hit(aw_addr_r, `NVAC_OFS_UNLK)) begin
				if (wbyte == `NVAC_KEY1) begin
					unlock_r <= 2'h1; // RQ16
				end else if (wbyte == `NVAC_KEY2 && unlock_r == 2'h1) begin
					unlock_r <= 2'h2; // RQ16
				end else begin
					unlock_r <= 2'h0;
				end
			end else begin
				unlock_r <= 2'h0; // RQ16
			end
		end
	end

	// table stores fill the holding registers for a block write
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			hold_idx_r <= 6'h0;
		end else if (wr_go && hit(aw_addr_r, `NVAC_OFS_TSTORE)) begin
			hold_mem[hold_idx_r] <= table_latch_reg_r; // RQ13
			hold_idx_r <= hold_idx_r + 6'h1;
		end else if (state_r == NVAC_DONE && ctrl_r.target == `NVAC_TGT_PFM) begin
			hold_idx_r <= 6'h0;
		end
	end

	// control register: launch bits set by software, cleared by hardware
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ctrl_r <= '0; // RQ6
		end else begin
			if (wr_go && hit(aw_addr_r, `NVAC_OFS_CTRL) && state_r == NVAC_IDLE) begin
				ctrl_r.target <= wbyte[`NVAC_CTRL_TGT_LO+1:`NVAC_CTRL_TGT_LO]; // RQ5
				ctrl_r.free <= wbyte[`NVAC_CTRL_FREE];
				ctrl_r.modify_permit <= wbyte[`NVAC_CTRL_MODIFY_PERMIT];
				// read launch refused when program memory is targeted
				if (wbyte[`NVAC_CTRL_RD] && wbyte[`NVAC_CTRL_TGT_LO+1:`NVAC_CTRL_TGT_LO]
					!= `NVAC_TGT_PFM) begin
					ctrl_r.rd <= 1'b1; // RQ11 RQ10
				end
				// zero writes never clear the launch bit
				if (wbyte[`NVAC_CTRL_WR] && ctrl_r.modify_permit && unlock_r == 2'h2
					&& !wbyte[`NVAC_CTRL_RD]) begin
					ctrl_r.wr <= 1'b1; // RQ6 RQ8 RQ16 RQ10
				end
			end
			if (state_r == NVAC_READ) begin
				ctrl_r.rd <= 1'b0; // RQ15
			end
			if (state_r == NVAC_DONE) begin
				ctrl_r.wr <= 1'b0; // RQ8
			end
		end
	end

	// access sequencer
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_r <= NVAC_IDLE;
		end else begin
			case (state_r)
				NVAC_IDLE: begin
					if (ctrl_r.wr) begin
						state_r <= NVAC_ERASE; // RQ3
					end else if (ctrl_r.rd) begin
						state_r <= NVAC_READ; // RQ10
					end
				end
				NVAC_READ: state_r <= NVAC_IDLE;
				NVAC_ERASE: state_r <= NVAC_PROG;
				NVAC_PROG: begin
					if (timer_expired) begin
						state_r <= NVAC_DONE; // RQ4
					end
				end
				NVAC_DONE: state_r <= NVAC_IDLE;
				default: state_r <= NVAC_IDLE;
			endcase
		end
	end

	// array updates: erase then program, one byte for the data EEPROM
	always_ff @(posedge i_clock) begin
		if (state_r == NVAC_ERASE && ctrl_r.target[1] == 1'b0
			&& ctrl_r.target[0] == 1'b0) begin
			eeprom_mem[nv_addr_low_r] <= `NVAC_ERASED; // RQ3
		end else if (state_r == NVAC_DONE) begin
			if (ctrl_r.target == 2'h0) begin
				eeprom_mem[nv_addr_low_r] <= nv_data_reg_r; // RQ2 RQ3
			end else if (ctrl_r.target == `NVAC_TGT_PFM && !ctrl_r.free) begin
				for (int i = 0; i < `NVAC_HOLD_N; i++) begin
					pfm_mem[{pfm_addr[9:6], 6'(i)}] <= hold_mem[i]; // RQ13
				end
			end else if (ctrl_r.target[0]) begin
				cfg_mem[nv_addr_low_r] <= nv_data_reg_r; // RQ5
			end
		end
	end

	// data register: software write or a read result
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			nv_data_reg_r <= 8'h00;
		end else if (state_r == NVAC_READ) begin
			if (ctrl_r.target[0]) begin
				nv_data_reg_r <= cfg_mem[nv_addr_low_r]; // RQ5
			end else begin
				nv_data_reg_r <= eeprom_mem[nv_addr_low_r]; // RQ15 RQ2
			end
		end else if (wr_go && hit(aw_addr_r, `NVAC_OFS_DATA)) begin
			nv_data_reg_r <= wbyte; // RQ1
		end
	end

	// fault flag and sticky done flag; set wins over a clearing read
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			program_fault_flag_r <= 1'b0;
			nv_done_flag_r <= 1'b0;
			done_mask_r <= 1'b0;
			o_irq <= 1'b0;
			o_cpu_stall <= 1'b0;
		end else begin
			if (timer_start) begin
				program_fault_flag_r <= 1'b1; // RQ7
			end else if (timer_expired) begin
				program_fault_flag_r <= 1'b0; // RQ7
			end
			if (state_r == NVAC_DONE) begin
				nv_done_flag_r <= 1'b1; // RQ9
			end else if (rd_go && hit(i_araddr, `NVAC_OFS_PERIPHERAL_FLAG_REG7)) begin
				nv_done_flag_r <= 1'b0; // RQ9
			end
			if (wr_go && hit(aw_addr_r, `NVAC_OFS_MASK)) begin
				done_mask_r <= wbyte[`NVAC_PERIPHERAL_FLAG_REG7_DONE];
			end
			o_irq <= nv_done_flag_r && done_mask_r;
			// core stalls while program memory is being programmed
			o_cpu_stall <= ctrl_r.wr && ctrl_r.target == `NVAC_TGT_PFM;
		end
	end

	nvac_prog_timer #(
		.CYCLES(PROG_CYCLES)
	) u_timer (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_start(timer_start), // RQ4
		.o_expired(timer_expired)
	);
endmodule : nvac_access_ctrl
`default_nettype wire

/* File: rtl/nvac_defines.svh */
// Overview of operation
// [RQ1] The data EEPROM is reached only through registers: a data register for the byte and a high/low address pair (code uses the low byte only).
// [RQ2] Reads and writes of the data EEPROM move one byte at a time.
// [RQ3] A byte write erases the addressed location first and then programs the new value, with no erase command.
// [RQ4] Each write lasts until an internal programming timer expires, and completion is signalled only then.
// [RQ5] A two-bit target field steers each access to program memory, data EEPROM or the ID/configuration space.
// [RQ6] The write permit bit gates every write and is clear after reset.
// [RQ7] The write error flag is set when a write launches and cleared when the programming timer expires.
// [RQ8] Software may set the write launch bit but not clear it; hardware clears it when the write ends.
// [RQ9] Completion of a write sets the done flag in peripheral flag register 7, which stays set until software clears it.
// [RQ10] Setting the read launch bit starts a read and setting the write launch bit starts an erase/write; hardware clears each.
// [RQ11] The read launch bit cannot be set while the target field selects program memory.
// [RQ12] Software writes 55h then 0AAh to the unlock register with interrupts off before launching a write.
// [RQ13] Each table store deposits the table latch byte into a holding register; a launched write programs the block.
// [RQ14] Software selects program memory, sets the permit, clears erase select, unlocks per block, then clears the permit.
// [RQ15] A data EEPROM read places the addressed byte in the data register before software can read it, then clears read launch.
// [RQ16] A write launch is ignored unless the two unlock values were written in order immediately before it.
`ifndef NVAC_DEFINES_SVH
`define NVAC_DEFINES_SVH
// register byte offsets
`define NVAC_OFS_DATA 8'h00
`define NVAC_OFS_ADRL 8'h04
`define NVAC_OFS_ADRH 8'h08
`define NVAC_OFS_CTRL 8'h0C
`define NVAC_OFS_UNLK 8'h10
`define NVAC_OFS_LATCH 8'h14
`define NVAC_OFS_TSTORE 8'h18
`define NVAC_OFS_PERIPHERAL_FLAG_REG7 8'h1C
`define NVAC_OFS_MASK 8'h20
// control register fields
`define NVAC_CTRL_RD 0
`define NVAC_CTRL_WR 1
`define NVAC_CTRL_MODIFY_PERMIT 2
`define NVAC_CTRL_ERR 3
`define NVAC_CTRL_FREE 4
`define NVAC_CTRL_TGT_LO 6
// done flag position in flag register 7
`define NVAC_PERIPHERAL_FLAG_REG7_DONE 5
// target encodings
`define NVAC_TGT_PFM 2'h2
// unlock key values
`define NVAC_KEY1 8'h55
`define NVAC_KEY2 8'hAA
// programming timer: time in ns, cycles at 10 ns
`define NVAC_PROG_NS 4000000
`define NVAC_CLK_NS 10
`define NVAC_PROG_CYC (`NVAC_PROG_NS / `NVAC_CLK_NS)
`define NVAC_ERASED 8'hFF
`define NVAC_HOLD_N 64
`endif

/* File: rtl/nvac_pkg.sv */
package nvac_pkg;
	typedef enum logic [2:0] {
		NVAC_IDLE = 3'b000,
		NVAC_READ = 3'b001,
		NVAC_ERASE = 3'b010,
		NVAC_PROG = 3'b011,
		NVAC_DONE = 3'b100
	} nvac_state_t;
	typedef struct packed {
		logic [1:0] target;
		logic free;
		logic modify_permit;
		logic wr;
		logic rd;
	} nvac_ctrl_t;
endpackage : nvac_pkg

/* File: rtl/nvac_prog_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nvac_defines.svh"
// internal programming timer: counts the write time once started
module nvac_prog_timer #(
	parameter int unsigned CYCLES = `NVAC_PROG_CYC
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// control
	input wire logic i_start,
	output logic o_expired
);
	logic [31:0] count_r;
	logic run_r;

	// count down; expiry is a one-cycle pulse
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			count_r <= 32'h0;
			run_r <= 1'b0;
			o_expired <= 1'b0;
		end else begin
			o_expired <= 1'b0;
			if (i_start) begin
				count_r <= CYCLES - 32'h1;
				run_r <= 1'b1;
			end else if (run_r) begin
				if (count_r == 32'h0) begin
					run_r <= 1'b0;
					o_expired <= 1'b1;
				end else begin
					count_r <= count_r - 32'h1;
				end
			end
		end
	end
endmodule : nvac_prog_timer
`default_nettype wire

/* File: testbench/nvac_access_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level watch on bus timing and the program stall
module nvac_access_ctrl_chk #(
	parameter int unsigned PROG_CYCLES = 20
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// bus
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_rresp,
	input wire logic o_rvalid,
	input wire logic i_rready,
	// status
	input wire logic o_cpu_stall
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	logic [31:0] stall_cnt_r;
	logic [3:0] w_gap_r;
	// stall length so far; zero while idle so each stall is judged alone
	always_ff @(posedge i_clock) begin
		if (i_rst || !o_cpu_stall) begin
			stall_cnt_r <= 32'h0;
		end else begin
			stall_cnt_r <= stall_cnt_r + 32'h1;
		end
	end
	// cycles since the last data beat, saturating
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			w_gap_r <= 4'hF;
		end else if (i_wvalid && o_wready) begin
			w_gap_r <= 4'h0;
		end else if (w_gap_r != 4'hF) begin
			w_gap_r <= w_gap_r + 4'h1;
		end
	end
	bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
		else $error("write response dropped early");
	rdata_hold_a: assert property (o_rvalid && !i_rready |=>
		o_rvalid && $stable(o_rdata)) else $error("read data not held");
	rd_latency_a: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read answer late");
	wr_latency_a: assert property (i_awvalid && o_awready && i_wvalid &&
		o_wready |-> ##[1:2] o_bvalid) else $error("write answer late");
	rd_err_a: assert property (i_arvalid && o_arready && (i_araddr > 8'h20 ||
		i_araddr[1:0] != 2'h0) |=> o_rresp == 2'h2) else $error("bad read ok");
	rd_ok_a: assert property (i_arvalid && o_arready && i_araddr <= 8'h20 &&
		i_araddr[1:0] == 2'h0 |=> o_rresp == 2'h0) else $error("good read err");
	stall_cause_a: assert property ($rose(o_cpu_stall) |-> w_gap_r < 4'h6)
		else $error("stall without a launch");
	stall_len_a: assert property ($fell(o_cpu_stall) |->
		stall_cnt_r >= PROG_CYCLES - 1 && stall_cnt_r <= PROG_CYCLES + 16)
		else $error("stall length off");
endmodule : nvac_access_ctrl_chk
bind nvac_access_ctrl nvac_access_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (
	.i_clock(i_clock), .i_rst(i_rst), .i_awvalid(i_awvalid),
	.o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
	.o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
	.i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
	.o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
	.o_cpu_stall(o_cpu_stall));
`default_nettype wire

/* File: testbench/nvac_access_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nvac_defines.svh"
`define CHECK(nm, exp, got) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		err_count++; \
		$display("BAD %s exp %0h got %0h", nm, exp, got); \
	end \
end
module nvac_access_ctrl_tb;
	localparam int PROG = 20;
	localparam logic [7:0] RDB = 8'h01, WRB = 8'h02, EN = 8'h04;
	logic clock, rst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq, stall;
	logic [7:0] awaddr, araddr;
	logic [1:0] bresp, rresp, rs;
	logic [3:0] strb;
	logic [31:0] wdata, rdata, rq;
	int err_count = 0, comparisons = 0, cyc = 0, t0;
	nvac_access_ctrl #(.PROG_CYCLES(PROG)) uut (
		.i_clock(clock), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(strb),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.o_irq(irq), .o_cpu_stall(stall));
	// free-running clock and a cycle count for timing checks
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;
	task automatic end_sim();
		$display("counts: %0d compared, %0d bad", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim
	// a wait that ran out ends the run rather than hanging
	task automatic guard(input int n);
		if (n > 200) begin
			err_count++;
			end_sim();
		end
	endtask : guard
	// answer is sampled before the channel flags move on
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_d, w_d, done;
		int n;
		{aw_d, w_d, done} = 3'h0;
		n = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		while (!done) begin
			@(posedge clock);
			n++;
			guard(n);
			done = aw_d && w_d && bvalid;
			rs = done ? bresp : rs;
			aw_d = aw_d | awready;
			w_d = w_d | wready;
			awvalid <= !aw_d;
			wvalid <= !w_d;
			bready <= !done;
		end
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic ar_d, done;
		int n;
		{ar_d, done} = 2'h0;
		n = 0;
		@(posedge clock);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		while (!done) begin
			@(posedge clock);
			n++;
			guard(n);
			done = ar_d && rvalid;
			rq = done ? rdata : rq;
			rs = done ? rresp : rs;
			ar_d = ar_d | arready;
			arvalid <= !ar_d;
			rready <= !done;
		end
	endtask : rd
	task automatic ctl(input logic [7:0] v);
		wr(`NVAC_OFS_CTRL, {24'h0, v});
	endtask : ctl
	// keys must be the last two writes before the launch
	task automatic try_wr(input logic [7:0] k1, input logic [7:0] k2);
		wr(`NVAC_OFS_UNLK, {24'h0, k1});
		wr(`NVAC_OFS_UNLK, {24'h0, k2});
		ctl(EN | WRB);
	endtask : try_wr
	task automatic poll(input int b);
		int n;
		for (n = 0; n < 60; n++) begin
			rd(`NVAC_OFS_CTRL);
			if (rq[b] === 1'b0) break;
		end
		guard(n == 60 ? 999 : 0);
	endtask : poll
	task automatic nv_write(input logic [7:0] a, input logic [7:0] d);
		wr(`NVAC_OFS_ADRL, {24'h0, a});
		wr(`NVAC_OFS_DATA, {24'h0, d});
		ctl(EN);
		try_wr(8'h55, 8'hAA);
		poll(1);
	endtask : nv_write
	task automatic nv_read(input logic [7:0] a);
		wr(`NVAC_OFS_ADRL, {24'h0, a});
		wr(`NVAC_OFS_DATA, 32'h0);
		ctl(RDB);
		rd(`NVAC_OFS_DATA);
	endtask : nv_read
	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata} = 48'h0;
		strb = 4'hF;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		rd(`NVAC_OFS_CTRL);
		`CHECK("ctrl reset", 4'h0, rq[3:0])
		// refused launches: no permit, keys swapped, wrong second key
		ctl(8'h00);
		try_wr(8'h55, 8'hAA);
		rd(`NVAC_OFS_CTRL);
		`CHECK("wr no permit", 1'b0, rq[1])
		ctl(EN);
		try_wr(8'hAA, 8'h55);
		rd(`NVAC_OFS_CTRL);
		`CHECK("wr swapped", 1'b0, rq[1])
		try_wr(8'h55, 8'h33);
		rd(`NVAC_OFS_CTRL);
		`CHECK("wr bad key", 1'b0, rq[1])
		$display("test lock done");
		wr(`NVAC_OFS_MASK, 32'h20);
		nv_write(8'h03, 8'h5A);
		wr(`NVAC_OFS_DATA, 32'hA5);
		try_wr(8'h55, 8'hAA);
		t0 = cyc;
		rd(`NVAC_OFS_CTRL);
		`CHECK("wr busy", 2'h3, {rq[3], rq[1]})
		ctl(EN);
		rd(`NVAC_OFS_CTRL);
		`CHECK("wr held", 1'b1, rq[1])
		poll(1);
		`CHECK("wr time", 1'b1, cyc - t0 >= PROG - 2)
		`CHECK("err clear", 1'b0, rq[3])
		repeat (3) @(posedge clock);
		`CHECK("irq on", 1'b1, irq)
		rd(`NVAC_OFS_PERIPHERAL_FLAG_REG7);
		rd(`NVAC_OFS_PERIPHERAL_FLAG_REG7);
		`CHECK("done clear", 1'b0, rq[5])
		`CHECK("irq off", 1'b0, irq)
		$display("test write done");
		// masked: flag still set, no interrupt; byte 3 is erased before A5 goes in, so it reads A5
		wr(`NVAC_OFS_MASK, 32'h0);
		nv_write(8'h04, 8'h3C);
		repeat (3) @(posedge clock);
		`CHECK("irq masked", 1'b0, irq)
		rd(`NVAC_OFS_PERIPHERAL_FLAG_REG7);
		`CHECK("done masked", 1'b1, rq[5])
		nv_read(8'h03);
		`CHECK("byte 3", 8'hA5, rq[7:0])
		rd(`NVAC_OFS_CTRL);
		`CHECK("rd clear", 1'b0, rq[0])
		nv_read(8'h04);
		`CHECK("byte 4", 8'h3C, rq[7:0])
		$display("test read done");
		// a launched read would reload byte 4 (3C) over this value
		wr(`NVAC_OFS_DATA, 32'h77);
		ctl(8'h81);
		rd(`NVAC_OFS_DATA);
		`CHECK("pfm rd", 8'h77, rq[7:0])
		for (int t = 1; t < 4; t++) begin
			ctl({t[1:0], 6'h01});
			rd(`NVAC_OFS_CTRL);
			`CHECK("tgt rd", {t[1:0], 1'b0}, {rq[7:6], rq[0]})
		end
		$display("test target done");
		// program flash: latch, store, unlock, launch, drop permit
		rd(`NVAC_OFS_TSTORE);
		t0 = rq;
		wr(`NVAC_OFS_LATCH, 32'h33);
		wr(`NVAC_OFS_TSTORE, 32'h0);
		rd(`NVAC_OFS_TSTORE);
		`CHECK("hold idx", t0 + 1, rq)
		// launch keeps the program target; try_wr would clear it
		ctl(8'h84);
		wr(`NVAC_OFS_UNLK, 32'h55);
		wr(`NVAC_OFS_UNLK, 32'hAA);
		ctl(8'h86);
		// stall is registered one edge after the launch bit
		@(posedge clock);
		`CHECK("stall on", 1'b1, stall)
		poll(1);
		`CHECK("stall off", 1'b0, stall)
		ctl(8'h80);
		rd(`NVAC_OFS_PERIPHERAL_FLAG_REG7);
		$display("test flash done");
		rd(8'h24);
		`CHECK("rd unmapped", 2'h2, rs)
		rd(8'h02);
		`CHECK("rd unaligned", 2'h2, rs)
		wr(8'h24, 32'h0);
		`CHECK("wr unmapped", 2'h2, rs)
		ctl(8'h08);
		rd(`NVAC_OFS_CTRL);
		`CHECK("err ro", 3'h0, {rs, rq[3]})
		wr(`NVAC_OFS_ADRH, 32'h5);
		rd(`NVAC_OFS_ADRH);
		`CHECK("adr high", 8'h05, rq[7:0])
		// a write without byte lane 0 must leave the register alone
		strb <= 4'hE;
		wr(`NVAC_OFS_ADRH, 32'h9);
		strb <= 4'hF;
		rd(`NVAC_OFS_ADRH);
		`CHECK("strb skip", 10'h005, {rs, rq[7:0]})
		$display("test errors done");
		end_sim();
	end
endmodule : nvac_access_ctrl_tb
`default_nettype wire
